// ===== lhsc_pkg.sv
// Constants for the sync control block: register map, fields, resets and timing.
// Assumes a 10 MHz system clock and an AXI4-Lite bus with 32-bit data.
package lhsc_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] LHSC_OFS_CTRL = 8'h00;
  localparam logic [7:0] LHSC_OFS_TIMER = 8'h04;
  localparam logic [7:0] LHSC_OFS_CMP = 8'h08;
  localparam logic [7:0] LHSC_OFS_STATUS = 8'h0C;
  localparam logic [7:0] LHSC_OFS_MASK = 8'h10;
  localparam logic [7:0] LHSC_OFS_EDGE_CFG = 8'h14;

  // ----------------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------------
  localparam int LHSC_CTRL_STOP_RISE = 7;
  localparam int LHSC_CTRL_SERIAL_MODE = 6;
  localparam int LHSC_CTRL_CMP_IE = 5;
  localparam int LHSC_CTRL_STOP_IE = 4;
  localparam int LHSC_CTRL_START_IE = 3;
  localparam int LHSC_CTRL_ENABLE = 2;
  localparam int LHSC_CTRL_EDGE_CLR = 1;
  localparam int LHSC_CTRL_RESET = 0;

  // ----------------------------------------------------------------------
  // Status and mask fields
  // ----------------------------------------------------------------------
  localparam int LHSC_STAT_START = 0;
  localparam int LHSC_STAT_STOP = 1;
  localparam int LHSC_STAT_CMP = 3;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] LHSC_CTRL_RESET_VAL = 8'h00;
  localparam logic [15:0] LHSC_CMP_RESET_VAL = 16'h0000;
  localparam logic [3:0] LHSC_MASK_RESET_VAL = 4'h0;
  localparam logic [7:0] LHSC_EDGE_CFG_RESET_VAL = 8'h32;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int LHSC_CLK_HZ = 10_000_000;
  localparam int LHSC_CLK_PERIOD_NS = 100;
  localparam int LHSC_TICK_HZ = 5_000_000;
  localparam int LHSC_TICK_DIV = LHSC_CLK_HZ / LHSC_TICK_HZ;
  localparam int LHSC_SELF_CLEAR_NS = 15_000;
  localparam int LHSC_SELF_CLEAR_CYCLES =
    (LHSC_SELF_CLEAR_NS + LHSC_CLK_PERIOD_NS - 1) / LHSC_CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------------
  localparam logic [1:0] LHSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] LHSC_RESP_SLVERR = 2'h2;

endpackage : lhsc_pkg

// ===== lhsc_self_clear.sv
// Self-clearing control bit: holds busy for a fixed number of cycles after a start pulse.
// Assumes start is a one-cycle pulse in the aclk domain.
`timescale 1ns/1ps
`default_nettype none

module lhsc_self_clear #(
  parameter int CYCLES = 150
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic start,
  output logic busy
);

  typedef struct packed {
    logic busy;
    logic [15:0] count;
  } lhsc_sc_state_t;

  lhsc_sc_state_t state;
  lhsc_sc_state_t next_state;

  always_comb begin
    next_state = state;
    if (start) begin
      next_state.busy = 1'b1;
      next_state.count = 16'(CYCLES - 1);
    end else if (state.busy) begin
      if (state.count == 16'h0000) begin
        next_state.busy = 1'b0;
      end else begin
        next_state.count = state.count - 16'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign busy = state.busy;

endmodule : lhsc_self_clear

`default_nettype wire

// ===== lhsc_sync_ctrl.sv
// Sync control block: control register, bit timer, edge counting and interrupts.
// Assumes bus_rx is synchronous to aclk and an AXI4-Lite master on the register bus.
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Mode bit 6 selects bit-serial bus mode when 1, LIN mode when 0.
// - Compare enable bit 5 raises interrupt when timer equals compare value.
// - Each compare interrupt sets compare flag bit 3 of status.
// - Stop interrupt enable bit 4 gates interrupts on stop conditions.
// - Start interrupt enable bit 3 gates interrupts on start conditions.
// - Synchronization runs only while enable bit 2 is 1.
// - Writing 1 to bit 1 clears edge counters; bit self-clears after 15 us.
// - Writing 1 to bit 0 resets sync logic; bit self-clears after 15 us.
// - In LIN mode, control bit 7 picks rising (1) or falling (0) edge count for stopping.
// - Bit timer counts a 5 MHz tick independent of bus rate.
module lhsc_sync_ctrl
  import lhsc_pkg::*;
#(
  parameter int SELF_CLEAR_CYCLES = LHSC_SELF_CLEAR_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Bus line
  input wire logic bus_rx,
  // Status outputs
  output logic irq,
  output logic bit_serial_bus_mode,
  output logic sync_enable,
  output logic sync_running
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] cmp;
    logic [3:0] status;
    logic [3:0] mask;
    logic [7:0] edge_cfg;
    logic [15:0] timer;
    logic running;
    logic [3:0] fall_cnt;
    logic [3:0] rise_cnt;
    logic bus_prev;
    logic tick_phase;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } lhsc_state_t;

  lhsc_state_t state;
  lhsc_state_t next_state;

  logic edge_clr_start;
  logic edge_clr_busy;
  logic reset_start;
  logic reset_busy;

  // ----------------------------------------------------------------------
  // Self-clearing control bits
  // ----------------------------------------------------------------------
  lhsc_self_clear #(
    .CYCLES(SELF_CLEAR_CYCLES)
  ) u_edge_clr (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(edge_clr_start),
    .busy(edge_clr_busy)
  );

  lhsc_self_clear #(
    .CYCLES(SELF_CLEAR_CYCLES)
  ) u_reset (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(reset_start),
    .busy(reset_busy)
  );

  // ----------------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------------
  logic wr_take;
  logic rd_take;

  // Address and data are taken together, once both are offered.
  assign wr_take = s_axi_awvalid && s_axi_wvalid && !state.bvalid;
  assign rd_take = s_axi_arvalid && !state.rvalid;
  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;
  assign s_axi_arready = !state.rvalid;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  logic [31:0] wmask;
  logic [31:0] cur_word;
  logic [31:0] new_word;
  logic [31:0] rd_word;
  logic rd_ok;
  logic wr_ok;
  logic tick;
  logic fall_edge;
  logic rise_edge;
  logic start_cond;
  logic stop_cond;
  logic cmp_hit;
  logic [15:0] timer_inc;
  logic [3:0] stop_count;
  logic [3:0] next_fall;
  logic [3:0] next_rise;
  logic [3:0] events;

  always_comb begin
    next_state = state;
    wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
             {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    edge_clr_start = 1'b0;
    reset_start = 1'b0;
    events = 4'h0;
    start_cond = 1'b0;
    stop_cond = 1'b0;
    cmp_hit = 1'b0;
    timer_inc = state.timer + 16'h0001;
    next_fall = state.fall_cnt;
    next_rise = state.rise_cnt;

    // Bus edges and the 5 MHz timer tick.
    fall_edge = state.bus_prev && !bus_rx;
    rise_edge = !state.bus_prev && bus_rx;
    next_state.bus_prev = bus_rx;
    next_state.tick_phase = !state.tick_phase;
    tick = state.tick_phase;

    if (state.ctrl[LHSC_CTRL_ENABLE]) begin
      if (fall_edge && state.fall_cnt != 4'hF) begin
        next_fall = state.fall_cnt + 4'h1;
      end
      if (rise_edge && state.rise_cnt != 4'hF) begin
        next_rise = state.rise_cnt + 4'h1;
      end
      stop_count = state.edge_cfg[7:4];
      if (state.ctrl[LHSC_CTRL_SERIAL_MODE]) begin
        // Bit-serial mode times each low pulse on the bus.
        start_cond = fall_edge;
        stop_cond = rise_edge && state.running;
      end else begin
        // LIN mode counts edges from the start of the break.
        start_cond = fall_edge && next_fall == state.edge_cfg[3:0];
        if (state.ctrl[LHSC_CTRL_STOP_RISE]) begin
          stop_cond = rise_edge && next_rise == stop_count && state.running;
        end else begin
          stop_cond = fall_edge && next_fall == stop_count && state.running;
        end
      end
      if (state.running && tick) begin
        next_state.timer = timer_inc;
        cmp_hit = timer_inc == state.cmp;
      end
      if (start_cond) begin
        next_state.running = 1'b1;
        next_state.timer = 16'h0000;
      end
      if (stop_cond) begin
        next_state.running = 1'b0;
      end
    end else begin
      stop_count = 4'h0;
      next_state.running = 1'b0;
    end
    next_state.fall_cnt = next_fall;
    next_state.rise_cnt = next_rise;

    events[LHSC_STAT_START] = start_cond && state.ctrl[LHSC_CTRL_START_IE];
    events[LHSC_STAT_STOP] = stop_cond && state.ctrl[LHSC_CTRL_STOP_IE];
    events[LHSC_STAT_CMP] = cmp_hit && state.ctrl[LHSC_CTRL_CMP_IE];

    // Edge counter clear holds counters at zero while its bit reads 1.
    if (edge_clr_busy) begin
      next_state.fall_cnt = 4'h0;
      next_state.rise_cnt = 4'h0;
    end

    // Sync reset holds edge counters, timer and running flag at zero and drops events while its bit reads 1.
    if (reset_busy) begin
      next_state.fall_cnt = 4'h0;
      next_state.rise_cnt = 4'h0;
      next_state.timer = 16'h0000;
      next_state.running = 1'b0;
      events = 4'h0;
    end

    // Read side.
    rd_ok = 1'b1;
    case (s_axi_araddr)
      LHSC_OFS_CTRL: begin
        rd_word = {24'h000000, state.ctrl[7:2], edge_clr_busy, reset_busy};
      end
      LHSC_OFS_TIMER: begin
        rd_word = {16'h0000, state.timer};
      end
      LHSC_OFS_CMP: begin
        rd_word = {16'h0000, state.cmp};
      end
      LHSC_OFS_STATUS: begin
        rd_word = {28'h0000000, state.status};
      end
      LHSC_OFS_MASK: begin
        rd_word = {28'h0000000, state.mask};
      end
      LHSC_OFS_EDGE_CFG: begin
        rd_word = {24'h000000, state.edge_cfg};
      end
      default: begin
        rd_word = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase

    if (rd_take) begin
      next_state.rvalid = 1'b1;
      next_state.rdata = rd_word;
      next_state.rresp = rd_ok ? LHSC_RESP_OKAY : LHSC_RESP_SLVERR;
      if (s_axi_araddr == LHSC_OFS_STATUS) begin
        next_state.status = 4'h0;
      end
    end else if (state.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
    end

    // Write side.
    wr_ok = 1'b1;
    cur_word = 32'h00000000;
    case (s_axi_awaddr)
      LHSC_OFS_CTRL: cur_word = {24'h000000, state.ctrl};
      LHSC_OFS_CMP: cur_word = {16'h0000, state.cmp};
      LHSC_OFS_MASK: cur_word = {28'h0000000, state.mask};
      LHSC_OFS_EDGE_CFG: cur_word = {24'h000000, state.edge_cfg};
      LHSC_OFS_TIMER, LHSC_OFS_STATUS: cur_word = 32'h00000000;
      default: wr_ok = 1'b0;
    endcase
    new_word = (cur_word & ~wmask) | (s_axi_wdata & wmask);

    if (wr_take) begin
      next_state.bvalid = 1'b1;
      next_state.bresp = wr_ok ? LHSC_RESP_OKAY : LHSC_RESP_SLVERR;
      case (s_axi_awaddr)
        LHSC_OFS_CTRL: begin
          next_state.ctrl = {new_word[7:2], 2'b00};
          edge_clr_start = s_axi_wstrb[0] && s_axi_wdata[LHSC_CTRL_EDGE_CLR];
          reset_start = s_axi_wstrb[0] && s_axi_wdata[LHSC_CTRL_RESET];
        end
        LHSC_OFS_CMP: next_state.cmp = new_word[15:0];
        LHSC_OFS_MASK: next_state.mask = new_word[3:0];
        LHSC_OFS_EDGE_CFG: next_state.edge_cfg = new_word[7:0];
        default: next_state.bvalid = 1'b1;
      endcase
    end else if (state.bvalid && s_axi_bready) begin
      next_state.bvalid = 1'b0;
    end

    // Events win over a read clear in the same cycle.
    next_state.status = next_state.status | events;
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '0;
      state.ctrl <= LHSC_CTRL_RESET_VAL;
      state.cmp <= LHSC_CMP_RESET_VAL;
      state.mask <= LHSC_MASK_RESET_VAL;
      state.edge_cfg <= LHSC_EDGE_CFG_RESET_VAL;
      state.bus_prev <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign s_axi_bvalid = state.bvalid;
  assign s_axi_bresp = state.bresp;
  assign s_axi_rvalid = state.rvalid;
  assign s_axi_rdata = state.rdata;
  assign s_axi_rresp = state.rresp;
  assign irq = |(state.status & state.mask);
  assign bit_serial_bus_mode = state.ctrl[LHSC_CTRL_SERIAL_MODE];
  assign sync_enable = state.ctrl[LHSC_CTRL_ENABLE];
  assign sync_running = state.running;

endmodule : lhsc_sync_ctrl

`default_nettype wire

// ===== lhsc_sync_ctrl_assertions.sv
// Concurrent checks on the register bus handshake and the control outputs.
// Assumes it is bound to lhsc_sync_ctrl and that the block has one clock.
`timescale 1ns/1ps
`default_nettype none
module lhsc_sync_ctrl_assertions
  import lhsc_pkg::*;
#(
  parameter int SELF_CLEAR_CYCLES = LHSC_SELF_CLEAR_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Control outputs
  input wire logic bit_serial_bus_mode,
  input wire logic sync_enable,
  input wire logic sync_running
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------------
  // Control writes, control outputs and bus handshakes
  // ----------------------------------------------------------------------
  sequence ctrl_wr;
    s_axi_awvalid && s_axi_awready && s_axi_awaddr == LHSC_OFS_CTRL && s_axi_wstrb[0];
  endsequence
  sequence rst_wr;
    ctrl_wr ##0 s_axi_wdata[LHSC_CTRL_RESET];
  endsequence

  serial_follow_a: assert property (ctrl_wr |=> bit_serial_bus_mode == $past(s_axi_wdata[6]))
    else $error("mode output does not follow the control write");
  enable_follow_a: assert property (ctrl_wr |=> sync_enable == $past(s_axi_wdata[2]))
    else $error("enable output does not follow the control write");
  idle_when_off_a: assert property ((!sync_enable)[*3] |-> !sync_running)
    else $error("timer runs while disabled");
  reset_stops_timer_a: assert property (rst_wr |-> ##3 (!sync_running)[*4])
    else $error("timer runs during sync reset");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write response late");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata))
    else $error("read response not held");
endmodule : lhsc_sync_ctrl_assertions

bind lhsc_sync_ctrl lhsc_sync_ctrl_assertions #(.SELF_CLEAR_CYCLES(SELF_CLEAR_CYCLES)) chk_i (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .bit_serial_bus_mode, .sync_enable,
  .sync_running
);
`default_nettype wire

// ===== lhsc_bus_peer.sv
// Bus peer model: drives a train of low pulses onto the released-high bus line.
// Assumes go is a one-cycle request in the aclk domain.
`timescale 1ns/1ps
`default_nettype none
module lhsc_bus_peer #(
  parameter int W = 20
) (
  // Clock and request
  input wire logic aclk,
  input wire logic go,
  input wire logic [3:0] pulses,
  // Bus line
  output logic bus_rx,
  output logic busy
);
  // The line rests high between trains, as a pulled-up bus does.
  initial begin
    bus_rx = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge aclk);
      if (go) begin
        busy <= 1'b1;
        repeat (pulses) begin
          bus_rx <= 1'b0;
          repeat (W) @(posedge aclk);
          bus_rx <= 1'b1;
          repeat (W) @(posedge aclk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule : lhsc_bus_peer
`default_nettype wire

// ===== lin_sync_control_lower_bits_bench.sv
// Self-checking bench for the sync control block over the register bus.
// Assumes lhsc_pkg, the bus peer model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module lin_sync_control_lower_bits_bench;
  import lhsc_pkg::*;
  localparam int SC = 8;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v, m;
  logic [3:0] s_axi_wstrb = 4'hF, np = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, go = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, busy;
  logic bus_rx, irq, bit_serial_bus_mode, sync_enable, sync_running;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [7:0] ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h32};
  int error_cnt = 0;
  int checked = 0;

  always #50 aclk = ~aclk;

  lhsc_sync_ctrl #(.SELF_CLEAR_CYCLES(SC)) uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bus_rx, .irq, .bit_serial_bus_mode,
    .sync_enable, .sync_running
  );
  lhsc_bus_peer #(.W(20)) peer (.aclk, .go, .pulses(np), .bus_rx, .busy);

  // ----------------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1 || s_axi_wready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic launch(input logic [3:0] n);
    @(posedge aclk);
    np <= n;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
  endtask : launch

  task automatic settle();
    do @(posedge aclk); while (busy === 1'b1);
    repeat (4) @(posedge aclk);
  endtask : settle

  // One frame: clear edge counters, send n pulses, check flags, irq and timer.
  task automatic run(input logic [31:0] c, input logic [3:0] n, input logic [31:0] es,
      input logic [31:0] lo, input logic [31:0] hi);
    wr(LHSC_OFS_CTRL, c | 32'h2);
    rd(LHSC_OFS_CTRL);
    chk(v, c | 32'h2);
    repeat (SC + 4) @(posedge aclk);
    rd(LHSC_OFS_CTRL);
    chk(v, c);
    rd(LHSC_OFS_STATUS);
    launch(n);
    settle();
    chk({31'h0, irq}, {31'h0, |(es & m)});
    rd(LHSC_OFS_STATUS);
    chk(v, es);
    rd(LHSC_OFS_STATUS);
    chk(v, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rd(LHSC_OFS_TIMER);
    chk({31'h0, v >= lo && v <= hi}, 32'h1);
    $display("test with control %h done", c);
  endtask : run

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    #(20000 * LHSC_CLK_PERIOD_NS);
    error_cnt++;
    conclude();
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(ofs[i]);
      chk(v, rv[i]);
    end
    rd(8'h20);
    chk({30'h0, r}, {30'h0, LHSC_RESP_SLVERR});
    wr(8'h20, 32'hFFFF);
    chk({30'h0, r}, {30'h0, LHSC_RESP_SLVERR});
    wr(LHSC_OFS_CMP, 32'hA);
    wr(LHSC_OFS_MASK, 32'hB);
    m = 32'hB;
    $display("test reset values done");
    for (int i = 0; i < 8; i++)
      run(32'h4 | (i << 3), 4'h3, {28'h0, i[2], 1'b0, i[1], i[0]}, 18, 22);
    wr(LHSC_OFS_MASK, 32'h0);
    m = 32'h0;
    run(32'h1C, 4'h3, 32'h3, 18, 22);
    wr(LHSC_OFS_MASK, 32'hB);
    m = 32'hB;
    run(32'h9C, 4'h3, 32'h3, 28, 32);
    run(32'h18, 4'h3, 32'h0, 28, 32);
    chk({31'h0, sync_enable}, 32'h0);
    wr(LHSC_OFS_CTRL, 32'h1E);
    repeat (SC + 4) @(posedge aclk);
    rd(LHSC_OFS_STATUS);
    launch(4'h3);
    do @(posedge aclk); while (sync_running !== 1'b1);
    wr(LHSC_OFS_CTRL, 32'h1D);
    rd(LHSC_OFS_CTRL);
    chk(v, 32'h1D);
    chk({31'h0, sync_running}, 32'h0);
    settle();
    rd(LHSC_OFS_CTRL);
    chk(v, 32'h1C);
    rd(LHSC_OFS_STATUS);
    chk(v, 32'h1);
    rd(LHSC_OFS_TIMER);
    chk(v, 32'h0);
    $display("test sync reset done");
    while (bus_rx !== 1'b1) @(posedge aclk);
    wr(LHSC_OFS_CMP, 32'h5);
    run(32'h7C, 4'h1, 32'hB, 8, 12);
    chk({31'h0, bit_serial_bus_mode}, 32'h1);
    conclude();
  end
endmodule : lin_sync_control_lower_bits_bench
`default_nettype wire
